// ### design/alarm_consts.svh
`ifndef ALARM_CONSTS_SVH
`define ALARM_CONSTS_SVH

// register byte addresses, low byte of each 16-bit word
`define ADDR_THRESHOLD_ONE    7'h20
`define ADDR_THRESHOLD_TWO    7'h22
`define ADDR_SAMPLE_COUNT_ONE 7'h24
`define ADDR_SAMPLE_COUNT_TWO 7'h26
`define ADDR_CONFIGURATION    7'h28
`define ADDR_DIAG_FLAGS       7'h3C

// reset value of every alarm register
`define REG_RESET             16'h0000

// threshold fields
`define THR_DIR_BIT           15
`define THR_VAL_MSB           13

// sample count field
`define CNT_MSB               7

// configuration fields
`define CFG_MODE_TWO          15
`define CFG_SRC_TWO_LSB       12
`define CFG_MODE_ONE          11
`define CFG_SRC_ONE_LSB       8
`define CFG_FILTER_BIT        4
`define CFG_OUT_EN_BIT        2
`define CFG_OUT_POL_BIT       1
`define CFG_OUT_LINE_BIT      0

// diagnostic flag positions
`define DIAG_ALARM_ONE_BIT    8

// source codes
`define SRC_DISABLED          3'h0
`define SRC_SUPPLY            3'h1
`define SRC_RATE              3'h2
`define SRC_AUX               3'h5
`define SRC_TEMP              3'h6

`endif

// ### design/alarm_pkg.sv
package alarm_pkg;

    // one set of measurement words, 14 bits each
    typedef struct packed {
        logic [13:0] supply;
        logic [13:0] rate;
        logic [13:0] aux;
        logic [13:0] temp;
    } source_set_t;

    // selected source: valid flag, signedness and value
    typedef struct packed {
        logic        valid;
        logic        is_signed;
        logic [13:0] value;
    } picked_t;

    // data-ready and general-purpose line settings from outside
    typedef struct packed {
        logic       ready_en;
        logic       ready_line;
        logic       ready_level;
        logic [1:0] gpio_oe;
        logic [1:0] gpio_level;
    } line_cfg_t;

endpackage

// ### design/dual_condition_alarm_monitor.sv
// Behaviour
// - two alarm channels, each with its own threshold, count, mode and source; filter bit 4 shared
// - threshold bit 15 picks greater or less
// - threshold bits 13:0 compared, bit 14 ignored
// - sample count bits 7:0, zero and one mean one
// - rate period is count times sample period
// - mode bits 15 and 11 select rate-of-change
// - three-bit source codes, zero disables alarm
// - bit 4 selects filtered or unfiltered data
// - bit 2 enables indicator, bit 0 picks line
// - bit 1 sets indicator active level
// - rate alarm compares change against threshold
// - all alarm registers reset to zero
// - status bits 9 and 8 report alarms
// - status flags clear on read, set again
// - line priority: data-ready, alarm, general-purpose
`timescale 1ns/1ps
`include "alarm_consts.svh"

module dual_condition_alarm_monitor (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    input  wire logic [6:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    output logic      [15:0]            reg_rdata_o,
    input  wire logic                   sample_tick_i,
    input  wire alarm_pkg::source_set_t raw_i,
    input  wire alarm_pkg::source_set_t filt_i,
    input  wire alarm_pkg::line_cfg_t   line_cfg_i,
    output logic      [1:0]             line_out_o,
    output logic      [1:0]             line_oe_o,
    output logic      [1:0]             alarm_active_o
);

    logic [15:0] thr_q [2];
    logic [15:0] thr_d [2];
    logic [15:0] cnt_reg_q [2];
    logic [15:0] cnt_reg_d [2];
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic [1:0]  flag_q;
    logic [1:0]  flag_d;
    logic [1:0]  cond_q;
    logic        status_read;

    // picks one source word from the code; unused codes are invalid
    function automatic alarm_pkg::picked_t pick(input logic [2:0] code,
                                                input alarm_pkg::source_set_t s);
        alarm_pkg::picked_t p;
        p = '{valid: 1'b1, is_signed: 1'b0, value: 14'h0000};
        unique case (code)
            `SRC_SUPPLY: p.value = s.supply;
            `SRC_RATE: begin
                p.value     = s.rate;
                p.is_signed = 1'b1;
            end
            `SRC_AUX:    p.value = s.aux;
            `SRC_TEMP: begin
                p.value     = s.temp;
                p.is_signed = 1'b1;
            end
            default:     p.valid = 1'b0;
        endcase
        return p;
    endfunction

    // widens a 14-bit word to 16-bit signed per its format
    function automatic logic signed [15:0] widen(input logic [13:0] v, input logic sgn);
        return sgn ? {{2{v[13]}}, v} : {2'b00, v};
    endfunction

    // word address of a byte address, shared by writes, reads and flag clear
    function automatic logic [6:0] word_of(input logic [6:0] a);
        return {a[6:1], 1'b0};
    endfunction

    // register writes, byte wide; odd address writes the high byte
    always_comb begin
        thr_d     = thr_q;
        cnt_reg_d = cnt_reg_q;
        cfg_d     = cfg_q;
        if (reg_wr_i) begin
            unique case (word_of(reg_addr_i))
                `ADDR_THRESHOLD_ONE:
                    thr_d[0][reg_addr_i[0]*8 +: 8] = reg_wdata_i;
                `ADDR_THRESHOLD_TWO:
                    thr_d[1][reg_addr_i[0]*8 +: 8] = reg_wdata_i;
                `ADDR_SAMPLE_COUNT_ONE:
                    cnt_reg_d[0][reg_addr_i[0]*8 +: 8] = reg_wdata_i;
                `ADDR_SAMPLE_COUNT_TWO:
                    cnt_reg_d[1][reg_addr_i[0]*8 +: 8] = reg_wdata_i;
                `ADDR_CONFIGURATION:
                    cfg_d[reg_addr_i[0]*8 +: 8] = reg_wdata_i;
                default: ;
            endcase
        end
    end

    // configuration storage
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thr_q     <= '{`REG_RESET, `REG_RESET};
            cnt_reg_q <= '{`REG_RESET, `REG_RESET};
            cfg_q     <= `REG_RESET;
        end else begin
            thr_q     <= thr_d;
            cnt_reg_q <= cnt_reg_d;
            cfg_q     <= cfg_d;
        end
    end

    // per-channel evaluation
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        localparam int MODE_POS = ch ? `CFG_MODE_TWO : `CFG_MODE_ONE;
        localparam int SRC_LSB  = ch ? `CFG_SRC_TWO_LSB : `CFG_SRC_ONE_LSB;

        alarm_pkg::picked_t     src;
        logic signed [15:0]     cur;
        logic signed [15:0]     thr_s;
        logic signed [15:0]     delta;
        logic        [15:0]     mag;
        logic        [7:0]      target;
        logic                   dir;
        logic                   rate_mode;
        logic                   cmp;
        logic                   cond_d;
        logic                   primed_q;
        logic                   primed_d;
        logic        [7:0]      tick_q;
        logic        [7:0]      tick_d;
        logic        [7:0]      tick_nx;
        logic signed [15:0]     base_q;
        logic signed [15:0]     base_d;

        // source, threshold and comparison terms
        always_comb begin
            src = pick(cfg_q[SRC_LSB +: 3],
                       cfg_q[`CFG_FILTER_BIT] ? filt_i : raw_i);
            rate_mode = cfg_q[MODE_POS];
            dir       = thr_q[ch][`THR_DIR_BIT];
            cur       = widen(src.value, src.is_signed);
            thr_s     = widen(thr_q[ch][`THR_VAL_MSB:0], src.is_signed);
            delta     = cur - base_q;
            mag       = delta[15] ? 16'(-delta) : 16'(delta);
            target    = (cnt_reg_q[ch][`CNT_MSB:0] > 8'h01) ?
                        cnt_reg_q[ch][`CNT_MSB:0] : 8'h01;
            tick_nx   = tick_q + 8'h01;
            if (rate_mode) begin
                cmp = dir ? (mag > {2'b00, thr_q[ch][`THR_VAL_MSB:0]}) :
                            (mag < {2'b00, thr_q[ch][`THR_VAL_MSB:0]});
            end else begin
                cmp = dir ? (cur > thr_s) : (cur < thr_s);
            end
        end

        // one evaluation per sample tick
        always_comb begin
            cond_d   = cond_q[ch];
            primed_d = primed_q;
            tick_d   = tick_q;
            base_d   = base_q;
            if (!src.valid) begin
                cond_d   = 1'b0;
                primed_d = 1'b0;
                tick_d   = 8'h00;
            end else if (sample_tick_i) begin
                if (!rate_mode) begin
                    cond_d   = cmp;
                    primed_d = 1'b0;
                    tick_d   = 8'h00;
                end else if (!primed_q) begin
                    base_d   = cur;
                    primed_d = 1'b1;
                    tick_d   = 8'h00;
                end else if (tick_nx >= target) begin
                    cond_d = cmp;
                    base_d = cur;
                    tick_d = 8'h00;
                end else begin
                    tick_d = tick_nx;
                end
            end
        end

        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cond_q[ch] <= 1'b0;
                primed_q   <= 1'b0;
                tick_q     <= 8'h00;
                base_q     <= 16'sh0000;
            end else begin
                cond_q[ch] <= cond_d;
                primed_q   <= primed_d;
                tick_q     <= tick_d;
                base_q     <= base_d;
            end
        end

        // sticky flag: a new set wins over a read clear
        assign flag_d[ch] = (sample_tick_i & cond_d) | (flag_q[ch] & ~status_read);
    end

    assign status_read = reg_rd_i && (word_of(reg_addr_i) == `ADDR_DIAG_FLAGS);

    // read data mux
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd_i) begin
            unique case (word_of(reg_addr_i))
                `ADDR_THRESHOLD_ONE:    rdata_d = thr_q[0];
                `ADDR_THRESHOLD_TWO:    rdata_d = thr_q[1];
                `ADDR_SAMPLE_COUNT_ONE: rdata_d = cnt_reg_q[0];
                `ADDR_SAMPLE_COUNT_TWO: rdata_d = cnt_reg_q[1];
                `ADDR_CONFIGURATION:    rdata_d = cfg_q;
                `ADDR_DIAG_FLAGS:
                    rdata_d = 16'(flag_q) << `DIAG_ALARM_ONE_BIT;
                default:                rdata_d = 16'h0000;
            endcase
        end
    end

    // read data and status flags
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 16'h0000;
            flag_q  <= 2'h0;
        end else begin
            rdata_q <= rdata_d;
            flag_q  <= flag_d;
        end
    end

    // digital line ownership by priority
    always_comb begin
        logic ind;
        ind = ((cond_q[0] | cond_q[1]) ~^ cfg_q[`CFG_OUT_POL_BIT]) ? 1'b1 : 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (line_cfg_i.ready_en && (line_cfg_i.ready_line == i[0])) begin
                line_out_o[i] = line_cfg_i.ready_level;
                line_oe_o[i]  = 1'b1;
            end else if (cfg_q[`CFG_OUT_EN_BIT] &&
                         (cfg_q[`CFG_OUT_LINE_BIT] == i[0])) begin
                line_out_o[i] = ind;
                line_oe_o[i]  = 1'b1;
            end else begin
                line_out_o[i] = line_cfg_i.gpio_level[i];
                line_oe_o[i]  = line_cfg_i.gpio_oe[i];
            end
        end
    end

    assign reg_rdata_o    = rdata_q;
    assign alarm_active_o = cond_q;

endmodule

// ### verification/alarm_checker.sv
`timescale 1ns/1ps
`include "alarm_consts.svh"
module alarm_checker (
    input wire logic                 clk_i,
    input wire logic                 rst_n_i,
    input wire logic                 reg_wr_i,
    input wire logic                 reg_rd_i,
    input wire logic [6:0]           reg_addr_i,
    input wire logic [7:0]           reg_wdata_i,
    input wire logic [15:0]          reg_rdata_o,
    input wire logic                 sample_tick_i,
    input wire alarm_pkg::line_cfg_t line_cfg_i,
    input wire logic [1:0]           line_out_o,
    input wire logic [1:0]           line_oe_o,
    input wire logic [1:0]           alarm_active_o
);
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic        stat_rd;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // shadow of the configuration word
    always_comb begin
        cfg_d = cfg_q;
        if (reg_wr_i && reg_addr_i == `ADDR_CONFIGURATION) cfg_d[7:0] = reg_wdata_i;
        if (reg_wr_i && reg_addr_i == (`ADDR_CONFIGURATION | 7'h01)) cfg_d[15:8] = reg_wdata_i;
        stat_rd = reg_rd_i && !sample_tick_i && (reg_addr_i | 7'h01) == (`ADDR_DIAG_FLAGS | 7'h01);
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cfg_q <= 16'h0000;
        else cfg_q <= cfg_d;
    end
    a_read_clears: assert property (stat_rd ##1 (!sample_tick_i)[*2] ##1 stat_rd
        |=> reg_rdata_o[9:8] == 2'h0)
        else $error("status flag survived a read");
    // a write of the source field drops the alarm one cycle after it lands
    a_alarm_on_tick: assert property ($changed(alarm_active_o)
        |-> $past(sample_tick_i) || $past(reg_wr_i, 2))
        else $error("alarm moved without a sample");
    a_ready_first: assert property (line_cfg_i.ready_en |-> line_oe_o[line_cfg_i.ready_line]
        && line_out_o[line_cfg_i.ready_line] == line_cfg_i.ready_level)
        else $error("data-ready line overridden");
    a_line_enable: assert property (!line_cfg_i.ready_en && cfg_q[2] |-> line_oe_o[cfg_q[0]])
        else $error("indicator line not driven");
    a_line_level: assert property (!line_cfg_i.ready_en && cfg_q[2]
        |-> line_out_o[cfg_q[0]] == (cfg_q[1] ~^ (|alarm_active_o)))
        else $error("indicator level wrong");
    a_off_one: assert property ($past(cfg_q[10:8]) == 3'h0 && cfg_q[10:8] == 3'h0
        |-> !alarm_active_o[0])
        else $error("disabled alarm one active");
    a_off_two: assert property ($past(cfg_q[14:12]) == 3'h0 && cfg_q[14:12] == 3'h0
        |-> !alarm_active_o[1])
        else $error("disabled alarm two active");
    a_reset_zero: assert property ($rose(rst_n_i) |-> reg_rdata_o == 16'h0000
        && alarm_active_o == 2'h0)
        else $error("outputs not cleared by reset");
endmodule
bind dual_condition_alarm_monitor alarm_checker i_chk (.*);

// ### verification/sensor_source_model.sv
`timescale 1ns/1ps
module sensor_source_model #(
    parameter int GAP = 8
) (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [1:0]        pick_i,
    input  wire logic              filt_sel_i,
    input  wire logic [13:0]       value_i,
    output logic                   tick_o,
    output alarm_pkg::source_set_t raw_o,
    output alarm_pkg::source_set_t filt_o
);
    logic [7:0]             cnt_q;
    alarm_pkg::source_set_t sel;
    // one field carries the value, the rest and the other set read zero
    always_comb begin
        sel = '0;
        sel[14 * (3 - pick_i) +: 14] = value_i;
        raw_o = filt_sel_i ? '0 : sel;
        filt_o = filt_sel_i ? sel : '0;
        tick_o = cnt_q == 8'h00;
    end
    // sample period counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) cnt_q <= 8'h01;
        else cnt_q <= (cnt_q == 8'(GAP - 1)) ? 8'h00 : cnt_q + 8'h01;
    end
endmodule

// ### verification/dual_condition_alarm_monitor_tb_top.sv
`timescale 1ns/1ps
`include "alarm_consts.svh"
module dual_condition_alarm_monitor_tb_top;
    logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, tick, fsel;
    logic [6:0]  reg_addr_i;
    logic [7:0]  reg_wdata_i;
    logic [15:0] reg_rdata_o;
    logic [13:0] val;
    logic [1:0]  pick, line_out_o, line_oe_o, alarm_active_o;
    logic [2:0]  codes [4] = '{`SRC_SUPPLY, `SRC_RATE, `SRC_AUX, `SRC_TEMP};
    alarm_pkg::source_set_t raw, filt;
    alarm_pkg::line_cfg_t   line_cfg_i;
    int num_errors = 0;
    int comparisons = 0;
    dual_condition_alarm_monitor i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .sample_tick_i(tick), .raw_i(raw), .filt_i(filt),
        .line_cfg_i(line_cfg_i), .line_out_o(line_out_o), .line_oe_o(line_oe_o),
        .alarm_active_o(alarm_active_o));
    sensor_source_model i_src (.clk_i(clk_i), .rst_n_i(rst_n_i), .pick_i(pick),
        .filt_sel_i(fsel), .value_i(val), .tick_o(tick), .raw_o(raw), .filt_o(filt));
    always #20 clk_i = ~clk_i;
    task automatic wrap_up();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // whole word as two byte writes
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d[7:0];
        @(posedge clk_i);
        reg_addr_i <= a | 7'h01;
        reg_wdata_i <= d[15:8];
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rc(input logic [6:0] a, input logic [15:0] exp);
        @(posedge clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        check(reg_rdata_o, exp);
    endtask
    task automatic ca(input logic [1:0] exp);
        check({14'h0, alarm_active_o}, {14'h0, exp});
    endtask
    // wait for the next sample, let it land, look one edge later
    task automatic tk();
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (tick !== 1'b1 && n < 20);
        if (tick !== 1'b1) begin
            num_errors++;
            wrap_up();
        end else begin
            @(posedge clk_i);
            @(posedge clk_i);
        end
    endtask
    initial begin
        {clk_i, rst_n_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
        {line_cfg_i, pick, fsel, val} = {7'h00, 2'h1, 1'b1, 14'h0000};
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) rc(`ADDR_THRESHOLD_ONE + 7'(2 * i), 16'h0000);
        wr(`ADDR_THRESHOLD_ONE, 16'hC100);
        wr(`ADDR_THRESHOLD_TWO, 16'h3F00);
        wr(`ADDR_CONFIGURATION, 16'h2217);
        rc(`ADDR_CONFIGURATION, 16'h2217);
        val <= 14'h0200;
        tk();
        ca(2'b01);
        check({13'h0, line_oe_o, line_out_o[1]}, 16'h0005);
        rc(`ADDR_DIAG_FLAGS, 16'h0100);
        rc(`ADDR_DIAG_FLAGS, 16'h0000);
        val <= 14'h3E00;
        tk();
        ca(2'b10);
        rc(`ADDR_DIAG_FLAGS, 16'h0200);
        fsel <= 1'b0;
        tk();
        ca(2'b00);
        wr(`ADDR_CONFIGURATION, 16'h2207);
        tk();
        ca(2'b10);
        wr(`ADDR_CONFIGURATION, 16'h2205);
        check({13'h0, line_oe_o, line_out_o[1]}, 16'h0004);
        wr(`ADDR_CONFIGURATION, 16'h2204);
        check({13'h0, line_oe_o, line_out_o[0]}, 16'h0002);
        line_cfg_i <= 7'b1010000;
        @(posedge clk_i);
        check({14'h0, line_oe_o[0], line_out_o[0]}, 16'h0003);
        line_cfg_i <= 7'h00;
        {fsel, val} <= {1'b1, 14'h0200};
        // every source code against every source
        for (int p = 0; p < 4; p++) begin
            pick <= 2'(p);
            for (int c = 0; c < 8; c++) begin
                wr(`ADDR_CONFIGURATION, 16'h0010 | (16'(c) << 8));
                tk();
                ca({1'b0, 3'(c) == codes[p]});
            end
        end
        // change over one sample, then over three
        {pick, val} <= {2'h1, 14'h0000};
        wr(`ADDR_CONFIGURATION, 16'h0A10);
        tk();
        val <= 14'h0200;
        tk();
        ca(2'b01);
        wr(`ADDR_CONFIGURATION, 16'h0010);
        wr(`ADDR_SAMPLE_COUNT_ONE, 16'h0003);
        val <= 14'h0000;
        wr(`ADDR_CONFIGURATION, 16'h0A10);
        tk();
        val <= 14'h0200;
        tk();
        tk();
        ca(2'b00);
        tk();
        ca(2'b01);
        // alarm two on change, less-than direction, one sample
        wr(`ADDR_CONFIGURATION, 16'hA010);
        tk();
        tk();
        ca(2'b10);
        wrap_up();
    end
endmodule
